// ===== core/tbtsc_pkg.sv
// Shared constants and types for the ten-meg status/control register block
package tbtsc_pkg;
   // Bus widths
   localparam int TBTSC_DATA_W = 16;
   localparam int TBTSC_ADDR_W = 16;

   // Register offsets from the I/O base
   localparam logic [15:0] OFF_PAGE_SELECT = 16'h00cc;
   localparam logic [15:0] OFF_PMD_CONTROL = 16'h00e4;
   localparam logic [15:0] OFF_TEN_MEG_STATUS_CONTROL = 16'h00e8;
   localparam logic [15:0] OFF_DSP_TUNING = 16'h00f4;
   localparam logic [15:0] OFF_SIGNAL_DETECT_TUNING = 16'h00f8;
   localparam logic [15:0] OFF_TEST_DATA_PORT = 16'h00fc;
   localparam logic [15:0] OFF_PHY_STATUS_SUMMARY = 16'h00b0;

   // Ten-meg status/control field positions
   localparam int TSC_LOOP_ON_BIT = 8;
   localparam int TSC_PULSE_SUPPRESS_BIT = 7;
   localparam int TSC_FORCE_LINK_BIT = 6;
   localparam int TSC_POL_OVERRIDE_BIT = 5;
   localparam int TSC_POL_FLAG_BIT = 4;
   localparam int TSC_AUTO_POL_OFF_BIT = 3;
   localparam int TSC_SQE_OFF_BIT = 1;
   localparam int TSC_GUARD_OFF_BIT = 0;

   // Reset value and writable bits of the ten-meg register
   localparam logic [15:0] TSC_RESET = 16'h0004;
   localparam logic [15:0] TSC_WMASK = 16'h01ef;

   // Phy status summary field positions
   localparam int PSS_POL_FLAG_BIT = 12;
   localparam int PSS_LINK_BIT = 2;

   // Tuning word store
   localparam int TUNE_WORDS = 5;
   localparam int TUNE_IDX_W = 3;
   localparam logic [15:0] TUNE_RESET = 16'h0000;
   localparam logic [2:0] IDX_PAGE_SELECT = 3'h0;
   localparam logic [2:0] IDX_PMD_CONTROL = 3'h1;
   localparam logic [2:0] IDX_DSP_TUNING = 3'h2;
   localparam logic [2:0] IDX_SIGNAL_DETECT_TUNING = 3'h3;
   localparam logic [2:0] IDX_TEST_DATA_PORT = 3'h4;

   // Host register access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } tbtsc_req_t;

   // Control lines toward the ten-meg transceiver
   typedef struct packed {
      logic loop_en;
      logic link_pulse_off;
      logic link_good;
      logic pol_invert;
      logic auto_pol_en;
      logic sqe_test_en;
      logic guard_en;
   } tbtsc_ctl_t;
endpackage : tbtsc_pkg

// ===== core/tbtsc_tune_mem.sv
// Small word store for the tuning registers, registered read data
`timescale 1ns/1ps
module tbtsc_tune_mem #(
   parameter int WORDS = 5,
   parameter int WIDTH = 16,
   parameter int IDX_W = 3
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Write port
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data
);
   import tbtsc_pkg::*;

   // Refuse a store the index cannot reach
   if (WORDS < 1 || WORDS > (1 << IDX_W) || WIDTH != TBTSC_DATA_W) begin : g_chk
      $error("tbtsc_tune_mem: bad WORDS, WIDTH or IDX_W");
   end

   logic [WIDTH-1:0] mem_reg [WORDS]; // Stored words
   logic [WIDTH-1:0] rd_data_reg; // Read output flop
   logic [WIDTH-1:0] rd_data_next;

   // One storage word per entry
   for (genvar i = 0; i < WORDS; i++) begin : g_word
      logic [WIDTH-1:0] word_next;
      always_comb begin
         word_next = mem_reg[i];
         if (wr_en && wr_idx == IDX_W'(i)) begin
            word_next = wr_data;
         end
      end
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            mem_reg[i] <= TUNE_RESET;
         end else begin
            mem_reg[i] <= word_next;
         end
      end
   end

   // Read mux, out-of-range index reads zero
   always_comb begin
      rd_data_next = '0;
      if (int'(rd_idx) < WORDS) begin
         rd_data_next = mem_reg[rd_idx];
      end
   end

   // Read data register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rd_data_reg <= '0;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;
endmodule : tbtsc_tune_mem

// ===== core/tbtsc_regs.sv
// Ten-meg status/control register, polarity flag and tuning registers
`timescale 1ns/1ps
//
// Contract
// - Bit 8 or basic-mode loopback enables loop
// - Bit 7 or override suppresses link pulses
// - Bit 6 or override forces good link
// - Bit 5 forces inverted receive polarity
// - Bit 4 latches high on inverted polarity
// - Flag mirrored in status; either read clears
// - Bit 3 disables automatic polarity correction
// - Bit 1 disables heartbeat in half-duplex ten
// - Heartbeat off at hundred or full duplex
// - Bit 0 disables the jabber guard
// - Registers decode at base plus offset
module tbtsc_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Host register access
   input wire logic [15:0] io_base,
   input wire tbtsc_pkg::tbtsc_req_t io_req,
   output logic [15:0] io_rdata,
   output logic io_rvalid,
   // Transceiver and mode inputs
   input wire logic basic_mode_loopback,
   input wire logic external_ten_meg_link_override,
   input wire logic ten_meg_link_raw,
   input wire logic polarity_inverted_seen,
   input wire logic speed_100,
   input wire logic full_duplex,
   // Transceiver controls
   output tbtsc_pkg::tbtsc_ctl_t ctl_out
);
   import tbtsc_pkg::*;

   logic [15:0] off; // Offset from base
   logic hit_tsc; // Ten-meg register hit
   logic hit_pss; // Status summary hit
   logic tune_hit; // Tuning store hit
   logic [TUNE_IDX_W-1:0] tune_idx; // Tuning store index
   logic pol_clear; // Read clears the flag

   logic [15:0] tsc_reg; // Ten-meg control bits
   logic [15:0] tsc_next;
   logic pol_reg; // Latched polarity flag
   logic pol_next;

   logic [15:0] rdata_reg; // Local read data
   logic [15:0] rdata_next;
   logic rvalid_reg; // Read answer strobe
   logic rvalid_next;
   logic sel_tune_reg; // Answer comes from store
   logic sel_tune_next;

   tbtsc_ctl_t ctl_reg; // Registered controls
   tbtsc_ctl_t ctl_next;
   logic [15:0] tune_rdata; // Store read data

   // Address decode relative to the base
   always_comb begin
      off = io_req.addr - io_base;
      hit_tsc = (off == OFF_TEN_MEG_STATUS_CONTROL);
      hit_pss = (off == OFF_PHY_STATUS_SUMMARY);
      tune_hit = 1'b1;
      tune_idx = IDX_PAGE_SELECT;
      unique case (off)
         OFF_PAGE_SELECT: tune_idx = IDX_PAGE_SELECT;
         OFF_PMD_CONTROL: tune_idx = IDX_PMD_CONTROL;
         OFF_TEST_DATA_PORT: tune_idx = IDX_TEST_DATA_PORT;
         OFF_DSP_TUNING: tune_idx = IDX_DSP_TUNING;
         OFF_SIGNAL_DETECT_TUNING: begin
            tune_idx = IDX_SIGNAL_DETECT_TUNING;
         end
         // Not a tuning register
         default: tune_hit = 1'b0;
      endcase
   end

   // Tuning register store
   tbtsc_tune_mem #(
      .WORDS(TUNE_WORDS),
      .WIDTH(TBTSC_DATA_W),
      .IDX_W(TUNE_IDX_W)
   ) u_tune (
      .mclk(mclk),
      .rst_n(rst_n),
      .wr_en(io_req.wr && tune_hit),
      .wr_idx(tune_idx),
      .wr_data(io_req.wdata),
      .rd_idx(tune_idx),
      .rd_data(tune_rdata)
   );

   // Control register and polarity flag next state
   always_comb begin
      tsc_next = tsc_reg;
      if (io_req.wr && hit_tsc) begin
         // Unused and read-only bits keep zero
         tsc_next = io_req.wdata & TSC_WMASK;
      end
      pol_clear = io_req.rd && (hit_tsc || hit_pss);
      // A new detection wins over a clearing read
      pol_next = polarity_inverted_seen || (pol_reg && !pol_clear);
   end

   // Control register and flag state
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tsc_reg <= TSC_RESET;
         pol_reg <= 1'b0;
      end else begin
         tsc_reg <= tsc_next;
         pol_reg <= pol_next;
      end
   end

   // Read answer next state
   always_comb begin
      rdata_next = '0;
      rvalid_next = io_req.rd;
      sel_tune_next = io_req.rd && tune_hit;
      if (io_req.rd && hit_tsc) begin
         rdata_next = tsc_reg;
         rdata_next[TSC_POL_FLAG_BIT] = pol_reg;
      end else if (io_req.rd && hit_pss) begin
         rdata_next[PSS_POL_FLAG_BIT] = pol_reg;
         rdata_next[PSS_LINK_BIT] = ctl_reg.link_good;
      end
   end

   // Read answer registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_reg <= '0;
         rvalid_reg <= 1'b0;
         sel_tune_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         sel_tune_reg <= sel_tune_next;
      end
   end

   assign io_rdata = sel_tune_reg ? tune_rdata : rdata_reg;
   assign io_rvalid = rvalid_reg;

   // Transceiver control next values
   always_comb begin
      ctl_next.loop_en = tsc_reg[TSC_LOOP_ON_BIT] || basic_mode_loopback;
      ctl_next.link_pulse_off = tsc_reg[TSC_PULSE_SUPPRESS_BIT]
         || external_ten_meg_link_override;
      ctl_next.link_good = tsc_reg[TSC_FORCE_LINK_BIT]
         || external_ten_meg_link_override || ten_meg_link_raw;
      ctl_next.pol_invert = tsc_reg[TSC_POL_OVERRIDE_BIT];
      ctl_next.auto_pol_en = !tsc_reg[TSC_AUTO_POL_OFF_BIT];
      // Heartbeat only in half-duplex ten-meg
      ctl_next.sqe_test_en = !tsc_reg[TSC_SQE_OFF_BIT]
         && !speed_100 && !full_duplex;
      ctl_next.guard_en = !tsc_reg[TSC_GUARD_OFF_BIT];
   end

   // Transceiver control registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctl_reg <= '0;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign ctl_out = ctl_reg;

   // Checks on the registered controls, polarity flag and read data
   a_loop_follow: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> ctl_reg.loop_en ==
      ($past(tsc_reg[TSC_LOOP_ON_BIT]) || $past(basic_mode_loopback)))
      else $error("loop enable does not follow its sources");
   a_pulse_off: assert property (@(posedge mclk) disable iff (!rst_n)
      external_ten_meg_link_override |=> ctl_reg.link_pulse_off)
      else $error("link pulses not suppressed by override");
   a_link_forced: assert property (@(posedge mclk) disable iff (!rst_n)
      (tsc_reg[TSC_FORCE_LINK_BIT] && !ten_meg_link_raw) |=>
      ctl_reg.link_good)
      else $error("forced link not reported good");
   a_pol_force: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> ctl_reg.pol_invert ==
      $past(tsc_reg[TSC_POL_OVERRIDE_BIT]))
      else $error("polarity override not applied");
   a_pol_latch: assert property (@(posedge mclk) disable iff (!rst_n)
      polarity_inverted_seen |=> pol_reg ##1
      (pol_reg || $past(pol_clear)))
      else $error("polarity flag not latched");
   a_pol_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      (io_req.rd && hit_pss && !polarity_inverted_seen) |=>
      !pol_reg && io_rvalid)
      else $error("status read did not clear polarity flag");
   a_auto_pol: assert property (@(posedge mclk) disable iff (!rst_n)
      (tsc_reg[TSC_AUTO_POL_OFF_BIT] && $past(tsc_reg[TSC_AUTO_POL_OFF_BIT]))
      |-> !ctl_reg.auto_pol_en)
      else $error("auto polarity still enabled");
   a_sqe_gate: assert property (@(posedge mclk) disable iff (!rst_n)
      (speed_100 || full_duplex) |=> !ctl_reg.sqe_test_en)
      else $error("heartbeat on outside half-duplex ten");
   a_guard_ctl: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> ctl_reg.guard_en ==
      !$past(tsc_reg[TSC_GUARD_OFF_BIT]))
      else $error("jabber guard control wrong");
   a_decode_read: assert property (@(posedge mclk) disable iff (!rst_n)
      (io_req.rd && hit_tsc) |=> io_rvalid &&
      io_rdata[15:5] == $past(tsc_reg[15:5]))
      else $error("ten-meg register read data wrong");
   a_unused_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      tsc_reg[15:9] == 7'h00)
      else $error("unused control bits not zero");
endmodule : tbtsc_regs

// ===== verification/tbtsc_regs_tb.sv
// Self-checking bench for the ten-meg status/control register block
`timescale 1ns/1ps
module tbtsc_regs_tb;
   import tbtsc_pkg::*;
   // Design inputs and outputs
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] io_base = 16'h0000;
   tbtsc_req_t io_req = '0;
   logic [15:0] io_rdata;
   logic io_rvalid;
   logic basic_mode_loopback = 1'b0;
   logic external_ten_meg_link_override = 1'b0;
   logic ten_meg_link_raw = 1'b0;
   logic polarity_inverted_seen = 1'b0;
   logic speed_100 = 1'b0;
   logic full_duplex = 1'b0;
   tbtsc_ctl_t ctl_out;
   // Bench bookkeeping
   int errors = 0;
   int checked = 0;
   logic [31:0] lfsr_state = 32'hbfb26131;
   logic [15:0] shadow; // Expected register content
   logic [15:0] rd_val;
   logic [31:0] rnd;
   logic [15:0] wval;
   logic [15:0] ctl_exp; // Expected controls, zero-extended
   tbtsc_ctl_t ec;
   logic [15:0] tune_off [5] = '{OFF_PAGE_SELECT, OFF_PMD_CONTROL,
      OFF_TEST_DATA_PORT, OFF_DSP_TUNING, OFF_SIGNAL_DETECT_TUNING};
   logic [15:0] tune_val [5] = '{16'h0001, 16'h189c, 16'h0000, 16'h5040,
      16'h008c};

   // Free-running 100 MHz clock
   always #5 mclk = ~mclk;

   // Design under test
   tbtsc_regs u_dut (
      .mclk(mclk),
      .rst_n(rst_n),
      .io_base(io_base),
      .io_req(io_req),
      .io_rdata(io_rdata),
      .io_rvalid(io_rvalid),
      .basic_mode_loopback(basic_mode_loopback),
      .external_ten_meg_link_override(external_ten_meg_link_override),
      .ten_meg_link_raw(ten_meg_link_raw),
      .polarity_inverted_seen(polarity_inverted_seen),
      .speed_100(speed_100),
      .full_duplex(full_duplex),
      .ctl_out(ctl_out)
   );

   // Galois shift register, fixed start value
   function automatic logic [31:0] next_rand();
      lfsr_state = {lfsr_state[30:0], 1'b0} ^
         (lfsr_state[31] ? 32'h000000c5 : 32'h00000000);
      return lfsr_state;
   endfunction : next_rand

   // Control lines expected from a register value and the mode inputs
   function automatic tbtsc_ctl_t expect_ctl(input logic [15:0] r);
      tbtsc_ctl_t c;
      c.loop_en = r[8] | basic_mode_loopback;
      c.link_pulse_off = r[7] | external_ten_meg_link_override;
      c.link_good = r[6] | external_ten_meg_link_override | ten_meg_link_raw;
      c.pol_invert = r[5];
      c.auto_pol_en = ~r[3];
      c.sqe_test_en = ~r[1] & ~speed_100 & ~full_duplex;
      c.guard_en = ~r[0];
      return c;
   endfunction : expect_ctl

   // Verdict and end of run
   task automatic wrap_up();
      if (errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   // One comparison, reported at once on mismatch
   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask : check

   // One-cycle write strobe at base plus offset
   task automatic wr_reg(input logic [15:0] off, input logic [15:0] data);
      @(negedge mclk);
      io_req.wr = 1'b1;
      io_req.addr = io_base + off;
      io_req.wdata = data;
      @(negedge mclk);
      io_req.wr = 1'b0;
   endtask : wr_reg

   // One-cycle read strobe, bounded wait for the answer
   task automatic rd_reg(input logic [15:0] off, output logic [15:0] data);
      @(negedge mclk);
      io_req.rd = 1'b1;
      io_req.addr = io_base + off;
      for (int i = 0; i < 4; i++) begin
         @(negedge mclk);
         io_req.rd = 1'b0;
         if (io_rvalid === 1'b1) begin
            data = io_rdata;
            return;
         end
      end
      errors++;
      wrap_up();
   endtask : rd_reg

   // One-cycle pulse of the inverted polarity detector
   task automatic pol_pulse();
      @(negedge mclk);
      polarity_inverted_seen = 1'b1;
      @(negedge mclk);
      polarity_inverted_seen = 1'b0;
   endtask : pol_pulse

   // Main sequence
   initial begin
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      repeat (2) @(negedge mclk);
      shadow = TSC_RESET;
      ctl_exp = {9'h0, expect_ctl(shadow)};
      check("ctl after reset", ctl_exp, {9'h0, ctl_out});
      rd_reg(OFF_TEN_MEG_STATUS_CONTROL, rd_val);
      check("reset value", shadow, rd_val);
      // Random register values and mode inputs, corners first
      for (int i = 0; i < 40; i++) begin
         rnd = next_rand();
         io_base = rnd[31:16];
         wval = 16'(next_rand()) | 16'h0004;
         if (i == 0) begin
            wval = 16'hffff;
         end else if (i == 1) begin
            wval = 16'h0004;
         end
         wr_reg(OFF_TEN_MEG_STATUS_CONTROL, wval);
         shadow = wval & TSC_WMASK;
         {basic_mode_loopback, external_ten_meg_link_override,
          ten_meg_link_raw, speed_100, full_duplex} = rnd[4:0];
         repeat (2) @(negedge mclk);
         ctl_exp = {9'h0, expect_ctl(shadow)};
         check("ctl", ctl_exp, {9'h0, ctl_out});
         rd_reg(OFF_TEN_MEG_STATUS_CONTROL, rd_val);
         check("readback", shadow, rd_val);
      end
      // Tuning sequence in order, then read back at a new base
      for (int k = 0; k < 5; k++) begin
         wr_reg(tune_off[k], tune_val[k]);
      end
      io_base = 16'h4a00;
      for (int k = 0; k < 5; k++) begin
         rd_reg(tune_off[k], rd_val);
         check("tuning word", tune_val[k], rd_val);
      end
      // Unmapped place reads zero, write there is dropped
      wr_reg(16'h00ea, 16'hffff);
      rd_reg(16'h00ea, rd_val);
      check("unmapped read", 16'h0000, rd_val);
      rd_reg(OFF_TEN_MEG_STATUS_CONTROL, rd_val);
      check("after unmapped write", shadow, rd_val);
      // Flag seen in one copy, then cleared in the other
      ec = expect_ctl(shadow);
      pol_pulse();
      rd_reg(OFF_TEN_MEG_STATUS_CONTROL, rd_val);
      check("flag set", shadow | 16'h0010, rd_val);
      rd_reg(OFF_PHY_STATUS_SUMMARY, rd_val);
      check("mirror cleared", {13'h0, ec.link_good, 2'h0}, rd_val);
      pol_pulse();
      rd_reg(OFF_PHY_STATUS_SUMMARY, rd_val);
      check("mirror set", {4'h1, 9'h0, ec.link_good, 2'h0}, rd_val);
      rd_reg(OFF_TEN_MEG_STATUS_CONTROL, rd_val);
      check("flag cleared", shadow, rd_val);
      wrap_up();
   end
endmodule : tbtsc_regs_tb
